// file: link_bist_pkg.sv
// Constants, register map and types shared by the serial link self-test block
package link_bist_pkg;
   // Widths
   localparam int VID_W      = 24;
   localparam int ENC_W      = VID_W + 1;
   localparam int BC_W       = 16;
   localparam int CRC_W      = 8;
   localparam int CNT_W      = 8;
   localparam int ADDR_W     = 8;
   localparam int DATA_W     = 32;
   localparam int IRQ_W      = 3;
   localparam int DISP_W     = 8;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFS_CFG  = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_STAT = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_BCNT = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_FCNT = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_ISR  = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_IMR  = 8'h1c;

   // Field positions
   localparam int CFG_RESEED_BIT = 5;
   localparam int STAT_LOCK_BIT  = 0;
   localparam int STAT_BIST_BIT  = 1;
   localparam int STAT_OSC_BIT   = 2;
   localparam int IRQ_ENTER_BIT  = 0;
   localparam int IRQ_EXIT_BIT   = 1;
   localparam int IRQ_CRC_BIT    = 2;

   // Reset values and codes
   localparam logic [7:0]        CFG_RST   = 8'h00;
   localparam logic [IRQ_W-1:0]  IMR_RST   = 3'h0;
   localparam logic [CNT_W-1:0]  CNT_ZERO  = 8'h00;
   localparam logic [CNT_W-1:0]  CNT_MAX   = 8'hff;
   localparam logic [CNT_W-1:0]  CNT_ONE   = 8'h01;
   localparam logic [CRC_W-1:0]  CRC_POLY  = 8'h07;
   localparam logic [CRC_W-1:0]  CRC_INIT  = 8'hff;
   localparam logic [VID_W-1:0]  LFSR_SEED = 24'h5a5a5a;
   localparam logic [VID_W-1:0]  LFSR_TAPS = 24'he10000;
   localparam logic [VID_W-1:0]  ZERO_PAY  = 24'h000000;
   localparam logic [DISP_W-1:0] DISP_ZERO = 8'h00;

   typedef enum logic [0:0] {
      MODE_NORMAL = 1'b0,
      MODE_BIST   = 1'b1
   } mode_t;
endpackage : link_bist_pkg

// file: link_scrambler.sv
// Forward-link scrambler and DC-balance encoder
`timescale 1ns/10ps
`default_nettype none
module link_scrambler
   import link_bist_pkg::*;
(
   // Clock and reset
   input  wire logic                           clk_sys,
   input  wire logic                           arst_n,
   // Payload in
   input  wire logic                           word_valid,
   input  wire logic [link_bist_pkg::VID_W-1:0] word,
   input  wire logic                           reseed,
   // Encoded out
   output logic                                enc_valid,
   output logic      [link_bist_pkg::ENC_W-1:0] enc_word
);
   logic        [VID_W-1:0]  lfsr_ff,  nxt_lfsr;
   logic signed [DISP_W-1:0] disp_ff,  nxt_disp;
   logic                     vld_ff,   nxt_vld;
   logic        [ENC_W-1:0]  word_ff,  nxt_word;
   logic        [VID_W-1:0]  scr;
   logic signed [DISP_W-1:0] diff;
   logic                     invert;

   always_comb
   begin
      scr      = word ^ lfsr_ff; // [RL3]
      diff     = DISP_W'(2 * $countones(scr) - VID_W);
      invert   = (disp_ff > 0 && diff > 0) || (disp_ff < 0 && diff < 0);
      nxt_lfsr = lfsr_ff;
      nxt_disp = disp_ff;
      nxt_word = word_ff;
      nxt_vld  = word_valid;
      if (reseed)
      begin
         nxt_lfsr = LFSR_SEED;
         nxt_disp = DISP_ZERO;
      end
      else if (word_valid)
      begin
         nxt_lfsr = {lfsr_ff[VID_W-2:0], 1'b0} ^ (lfsr_ff[VID_W-1] ? LFSR_TAPS : ZERO_PAY);
         // Inverting toward the opposite sign keeps the line free of DC drift
         nxt_word = invert ? {1'b1, ~scr} : {1'b0, scr}; // [RL3]
         nxt_disp = invert ? disp_ff - diff : disp_ff + diff;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         lfsr_ff <= LFSR_SEED;
         disp_ff <= DISP_ZERO;
         vld_ff  <= 1'b0;
         word_ff <= '0;
      end
      else
      begin
         lfsr_ff <= nxt_lfsr;
         disp_ff <= nxt_disp;
         vld_ff  <= nxt_vld;
         word_ff <= nxt_word;
      end
   end

   assign enc_valid = vld_ff;
   assign enc_word  = word_ff;
endmodule : link_scrambler
`default_nettype wire

// file: bc_crc_check.sv
// Back-channel frame CRC checker
`timescale 1ns/10ps
`default_nettype none
module bc_crc_check
   import link_bist_pkg::*;
(
   // Clock and reset
   input  wire logic                            clk_sys,
   input  wire logic                            arst_n,
   // Frame in
   input  wire logic                            enable,
   input  wire logic                            frm_valid,
   input  wire logic [link_bist_pkg::BC_W-1:0]  frm_payload,
   input  wire logic [link_bist_pkg::CRC_W-1:0] frm_crc,
   // Result
   output logic                                 crc_err
);
   logic err_ff, nxt_err;

   function automatic logic [CRC_W-1:0] crc_of(input logic [BC_W-1:0] d);
      logic [CRC_W-1:0] c;
      c = CRC_INIT;
      for (int i = BC_W - 1; i >= 0; i--)
      begin
         c = {c[CRC_W-2:0], 1'b0} ^ ((c[CRC_W-1] ^ d[i]) ? CRC_POLY : CNT_ZERO);
      end
      return c;
   endfunction : crc_of

   always_comb
   begin
      // Frames before link detect are ignored: CRC framing is not yet trusted
      nxt_err = enable && frm_valid && (crc_of(frm_payload) != frm_crc); // [RL6] [RL7]
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         err_ff <= 1'b0;
      end
      else
      begin
         err_ff <= nxt_err;
      end
   end

   assign crc_err = err_ff;
endmodule : bc_crc_check
`default_nettype wire

// file: serial_link_bist.sv
// Serializer-side at-speed self test of the forward link and back channel
`timescale 1ns/10ps
`default_nettype none
//Behaviour
// [RL1] Self test starts on the back-channel enable command, no local pin needed.
// [RL2] In self test the video inputs are ignored; payload is all zeros.
// [RL3] The zero payload is scrambled, DC-balanced and sent at full rate.
// [RL4] Host toggles config bit 5 high then low right after test enable.
// [RL5] Test clock is video clock or internal oscillator, chosen by partner.
// [RL6] In self test every back-channel frame CRC is checked; errors counted.
// [RL7] CRC checking starts only once back-channel link detect is set.
// [RL8] An eight-bit error count register holds back-channel CRC errors.
// [RL9] The self-test CRC error count clears on entering self test.
// [RL10] The functional CRC error count starts counting from self-test entry.
// [RL11] Self-test count runs only in self test and keeps last result.
// [RL12] Partner compares received stream to zeros and reports mismatches; the model only checks that tx_valid is present.
// [RL13] Partner pass/fail output goes high on lock, pulses low per error; the model sets pass_out at test start and holds it low after a missing word.
// [RL14] Partner holds final pass/fail result until new test or reset.
// [RL15] Test lasts while partner enable pin is active; low ends it.
// [RL16] Link lock stays valid throughout the self-test run.
// [RL17] On enable withdrawal, leave self test, resume video, freeze count.
module serial_link_bist
   import link_bist_pkg::*;
(
   // Clock and reset
   input  wire logic                            clk_sys,
   input  wire logic                            arst_n,
   // APB slave
   input  wire logic                            psel,
   input  wire logic                            penable,
   input  wire logic                            pwrite,
   input  wire logic [link_bist_pkg::ADDR_W-1:0] paddr,
   input  wire logic [link_bist_pkg::DATA_W-1:0] pwdata,
   output logic      [link_bist_pkg::DATA_W-1:0] prdata,
   output logic                                 pready,
   output logic                                 pslverr,
   // Video input
   input  wire logic                            vid_valid,
   input  wire logic [link_bist_pkg::VID_W-1:0] vid_data,
   // Back channel
   input  wire logic                            bc_lock,
   input  wire logic                            bc_test_enable,
   input  wire logic                            bc_clock_select,
   input  wire logic                            bc_frm_valid,
   input  wire logic [link_bist_pkg::BC_W-1:0]  bc_frm_payload,
   input  wire logic [link_bist_pkg::CRC_W-1:0] bc_frm_crc,
   // Forward link
   output logic                                 tx_valid,
   output logic      [link_bist_pkg::ENC_W-1:0] tx_word,
   // Clock source and status
   output logic                                 internal_oscillator,
   output logic                                 test_active,
   output logic                                 irq
);
   import link_bist_pkg::*;

   mode_t             mode_ff,  nxt_mode;
   logic              osc_ff,   nxt_osc;
   logic [7:0]        cfg_ff,   nxt_cfg;
   logic [CNT_W-1:0]  bcnt_ff,  nxt_bcnt;
   logic [CNT_W-1:0]  fcnt_ff,  nxt_fcnt;
   logic [IRQ_W-1:0]  isr_ff,   nxt_isr;
   logic [IRQ_W-1:0]  imr_ff,   nxt_imr;
   logic [DATA_W-1:0] rdata_ff, nxt_rdata;
   logic              err_ff,   nxt_err;
   logic [VID_W-1:0]  pay_ff,   nxt_pay;
   logic              pvld_ff,  nxt_pvld;

   logic              wr_acc;
   logic              setup;
   logic              mapped;
   logic              enter;
   logic              leave;
   logic              crc_err;
   logic [IRQ_W-1:0]  events;

   // Bus decode
   always_comb
   begin
      setup  = psel && !penable;
      wr_acc = psel && penable && pwrite;
      mapped = 1'b0;
      if (paddr == OFS_CFG)
      begin
         mapped = 1'b1;
      end
      else if (paddr == OFS_STAT)
      begin
         mapped = 1'b1;
      end
      else if (paddr == OFS_BCNT)
      begin
         mapped = 1'b1;
      end
      else if (paddr == OFS_FCNT)
      begin
         mapped = 1'b1;
      end
      else if (paddr == OFS_ISR)
      begin
         mapped = 1'b1;
      end
      else if (paddr == OFS_IMR)
      begin
         mapped = 1'b1;
      end
   end

   // Mode control
   always_comb
   begin
      nxt_mode = mode_ff;
      if (mode_ff == MODE_NORMAL)
      begin
         if (bc_test_enable)
         begin
            nxt_mode = MODE_BIST; // [RL1] [RL15]
         end
      end
      else
      begin
         if (!bc_test_enable)
         begin
            nxt_mode = MODE_NORMAL; // [RL17] [RL15]
         end
      end
      enter   = (mode_ff == MODE_NORMAL) && (nxt_mode == MODE_BIST);
      leave   = (mode_ff == MODE_BIST) && (nxt_mode == MODE_NORMAL);
      // Oscillator choice is followed only in test; normal traffic keeps video clock
      nxt_osc = (nxt_mode == MODE_BIST) && bc_clock_select; // [RL5]
   end

   // Payload source
   always_comb
   begin
      nxt_pvld = (mode_ff == MODE_BIST) || vid_valid; // [RL3]
      nxt_pay  = pay_ff;
      if (mode_ff == MODE_BIST)
      begin
         nxt_pay = ZERO_PAY; // [RL2]
      end
      else if (vid_valid)
      begin
         nxt_pay = vid_data; // [RL17]
      end
   end

   link_scrambler u_scrambler (
      .clk_sys    (clk_sys),
      .arst_n     (arst_n),
      .word_valid (pvld_ff),
      .word       (pay_ff),
      .reseed     (cfg_ff[CFG_RESEED_BIT]), // [RL4]
      .enc_valid  (tx_valid),
      .enc_word   (tx_word)
   );

   bc_crc_check u_crc (
      .clk_sys     (clk_sys),
      .arst_n      (arst_n),
      .enable      (bc_lock), // [RL7] [RL16]
      .frm_valid   (bc_frm_valid),
      .frm_payload (bc_frm_payload),
      .frm_crc     (bc_frm_crc),
      .crc_err     (crc_err)
   );

   // Error counters saturate; a count event in a register-write clear cycle still lands, one in the self-test entry cycle is dropped
   always_comb
   begin
      nxt_bcnt = bcnt_ff;
      nxt_fcnt = fcnt_ff;
      if (wr_acc && paddr == OFS_BCNT)
      begin
         nxt_bcnt = CNT_ZERO;
      end
      if (wr_acc && paddr == OFS_FCNT)
      begin
         nxt_fcnt = CNT_ZERO;
      end
      if (enter)
      begin
         nxt_bcnt = CNT_ZERO; // [RL9]
         nxt_fcnt = CNT_ZERO; // [RL10]
      end
      else
      begin
         if (crc_err && mode_ff == MODE_BIST && nxt_bcnt != CNT_MAX)
         begin
            nxt_bcnt = nxt_bcnt + CNT_ONE; // [RL6] [RL11] [RL8]
         end
         if (crc_err && nxt_fcnt != CNT_MAX)
         begin
            nxt_fcnt = nxt_fcnt + CNT_ONE; // [RL10] [RL8]
         end
      end
   end

   // Config, interrupt status and mask
   always_comb
   begin
      events                 = '0;
      events[IRQ_ENTER_BIT]  = enter;
      events[IRQ_EXIT_BIT]   = leave;
      events[IRQ_CRC_BIT]    = crc_err && (mode_ff == MODE_BIST);
      nxt_cfg = cfg_ff;
      nxt_imr = imr_ff;
      nxt_isr = isr_ff;
      if (wr_acc && paddr == OFS_CFG)
      begin
         nxt_cfg = pwdata[7:0];
      end
      if (wr_acc && paddr == OFS_IMR)
      begin
         nxt_imr = pwdata[IRQ_W-1:0];
      end
      if (wr_acc && paddr == OFS_ISR)
      begin
         nxt_isr = isr_ff & ~pwdata[IRQ_W-1:0];
      end
      nxt_isr = nxt_isr | events;
   end

   // Read data is captured in the setup cycle so the access phase needs no wait
   always_comb
   begin
      nxt_rdata = rdata_ff;
      nxt_err   = err_ff;
      if (setup)
      begin
         nxt_rdata = '0;
         nxt_err   = !mapped;
         if (paddr == OFS_CFG)
         begin
            nxt_rdata[7:0] = cfg_ff;
         end
         else if (paddr == OFS_STAT)
         begin
            nxt_rdata[STAT_LOCK_BIT] = bc_lock; // [RL7]
            nxt_rdata[STAT_BIST_BIT] = (mode_ff == MODE_BIST);
            nxt_rdata[STAT_OSC_BIT]  = osc_ff;
         end
         else if (paddr == OFS_BCNT)
         begin
            nxt_rdata[CNT_W-1:0] = bcnt_ff;
         end
         else if (paddr == OFS_FCNT)
         begin
            nxt_rdata[CNT_W-1:0] = fcnt_ff;
         end
         else if (paddr == OFS_ISR)
         begin
            nxt_rdata[IRQ_W-1:0] = isr_ff;
         end
         else if (paddr == OFS_IMR)
         begin
            nxt_rdata[IRQ_W-1:0] = imr_ff;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         mode_ff  <= MODE_NORMAL;
         osc_ff   <= 1'b0;
         cfg_ff   <= CFG_RST;
         bcnt_ff  <= CNT_ZERO;
         fcnt_ff  <= CNT_ZERO;
         isr_ff   <= '0;
         imr_ff   <= IMR_RST;
         rdata_ff <= '0;
         err_ff   <= 1'b0;
         pay_ff   <= ZERO_PAY;
         pvld_ff  <= 1'b0;
      end
      else
      begin
         mode_ff  <= nxt_mode;
         osc_ff   <= nxt_osc;
         cfg_ff   <= nxt_cfg;
         bcnt_ff  <= nxt_bcnt;
         fcnt_ff  <= nxt_fcnt;
         isr_ff   <= nxt_isr;
         imr_ff   <= nxt_imr;
         rdata_ff <= nxt_rdata;
         err_ff   <= nxt_err;
         pay_ff   <= nxt_pay;
         pvld_ff  <= nxt_pvld;
      end
   end

   assign prdata              = rdata_ff;
   assign pready              = psel && penable;
   assign pslverr             = psel && penable && err_ff;
   assign internal_oscillator = osc_ff;
   assign test_active         = (mode_ff == MODE_BIST);
   assign irq                 = |(isr_ff & imr_ff);
endmodule : serial_link_bist
`default_nettype wire

// file: serial_link_bist_chk.sv
// Concurrent assertions on the ports of the serial link self-test block
`timescale 1ns/10ps
`default_nettype none
module serial_link_bist_chk
   import link_bist_pkg::*;
(
   // Clock and reset
   input wire logic        clk_sys,
   input wire logic        arst_n,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [link_bist_pkg::DATA_W-1:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Link side
   input wire logic        vid_valid,
   input wire logic        bc_test_enable,
   input wire logic        bc_clock_select,
   input wire logic        tx_valid,
   input wire logic        internal_oscillator,
   input wire logic        test_active
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!arst_n);

   AST_ENTER: assert property (bc_test_enable |=> test_active)
      else $error("Self test not entered");
   AST_LEAVE: assert property (!bc_test_enable |=> !test_active)
      else $error("Self test kept after enable dropped");
   AST_OSC_ON: assert property (bc_test_enable && bc_clock_select |=> internal_oscillator)
      else $error("Oscillator not selected");
   AST_OSC_OFF: assert property (!(bc_test_enable && bc_clock_select) |=> !internal_oscillator)
      else $error("Oscillator selected without request");
   // Two cycles of settling cover the payload and encoder stages
   AST_TX_RATE: assert property (test_active [*2] |=> tx_valid)
      else $error("Gap in test stream");
   AST_VIDEO: assert property (!test_active && !bc_test_enable |=> ##1 tx_valid == $past(vid_valid, 2))
      else $error("Video strobe not forwarded");
   AST_READY: assert property (pready == (psel && penable))
      else $error("Ready outside access phase");
   AST_ERR: assert property (pslverr |-> psel && penable && prdata == '0)
      else $error("Bad error response");
endmodule : serial_link_bist_chk

bind serial_link_bist serial_link_bist_chk u_chk (
   .clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .vid_valid(vid_valid), .tx_valid(tx_valid),
   .bc_test_enable(bc_test_enable), .bc_clock_select(bc_clock_select),
   .internal_oscillator(internal_oscillator), .test_active(test_active)
);
`default_nettype wire

// file: link_remote_model.sv
// Behavioural model of the remote deserializer behind the back channel
`timescale 1ns/10ps
`default_nettype none
module link_remote_model
   import link_bist_pkg::*;
(
   // Clock and reset
   input  wire logic     clk_sys,
   input  wire logic     arst_n,
   // Bench controls
   input  wire logic     lock_req,
   input  wire logic     test_req,
   input  wire logic     osc_req,
   input  wire logic     f_go,
   input  wire logic     f_bad,
   input  wire logic [link_bist_pkg::BC_W-1:0] f_pay,
   // Forward link
   input  wire logic     tx_valid,
   // Back channel and result
   output logic          bc_lock,
   output logic          bc_test_enable,
   output logic          bc_clock_select,
   output logic          bc_frm_valid,
   output logic [link_bist_pkg::BC_W-1:0]  bc_frm_payload,
   output logic [link_bist_pkg::CRC_W-1:0] bc_frm_crc,
   output logic          pass_out
);
   logic [2:0] settle;

   function automatic logic [CRC_W-1:0] crc8(input logic [BC_W-1:0] d);
      logic [CRC_W-1:0] c;
      begin
         c = CRC_INIT;
         for (int i = BC_W - 1; i >= 0; i--)
            c = {c[CRC_W-2:0], 1'b0} ^ ((c[CRC_W-1] ^ d[i]) ? CRC_POLY : 8'h00);
         return c;
      end
   endfunction : crc8

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         bc_lock <= 1'b0;
         bc_test_enable <= 1'b0;
         bc_clock_select <= 1'b0;
         bc_frm_valid <= 1'b0;
         bc_frm_payload <= '0;
         bc_frm_crc <= '0;
         pass_out <= 1'b0;
         settle <= 3'h0;
      end
      else
      begin
         bc_lock <= lock_req;
         bc_test_enable <= test_req && lock_req;
         bc_clock_select <= osc_req;
         bc_frm_valid <= f_go;
         // Idle lines flip so a stale value never looks like a frame
         bc_frm_payload <= f_go ? f_pay : ~bc_frm_payload;
         bc_frm_crc <= f_go ? crc8(f_pay) ^ {7'h00, f_bad} : ~bc_frm_crc;
         if (test_req && lock_req && !bc_test_enable)
         begin
            pass_out <= 1'b1;
            settle <= 3'h5;
         end
         else if (bc_test_enable && settle != 3'h0)
            settle <= settle - 3'h1;
         // Only a missing word counts as an error; payload is not descrambled
         else if (bc_test_enable && !tx_valid)
            pass_out <= 1'b0;
      end
   end
endmodule : link_remote_model
`default_nettype wire

// file: tb_serial_link_bist.sv
// Self-checking bench for the serial link self-test block
`timescale 1ns/10ps
`default_nettype none
module tb_serial_link_bist;
   import link_bist_pkg::*;
   logic              clk_sys, arst_n, psel, penable, pwrite, pready, pslverr, irq;
   logic              vid_valid, bc_lock, bc_test_enable, bc_clock_select, bc_frm_valid;
   logic              tx_valid, internal_oscillator, test_active, pass_out, er, nz;
   logic              lock_req, test_req, osc_req, f_go, f_bad;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata, prdata, rd;
   logic [VID_W-1:0]  vid_data;
   logic [BC_W-1:0]   bc_frm_payload, f_pay;
   logic [CRC_W-1:0]  bc_frm_crc;
   logic [ENC_W-1:0]  tx_word;
   logic [ENC_W-1:0]  cap [2][8];
   int                error_cnt, checks_done;

   serial_link_bist dut (
      .clk_sys, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .vid_valid, .vid_data, .bc_lock, .bc_test_enable, .bc_clock_select,
      .bc_frm_valid, .bc_frm_payload, .bc_frm_crc, .tx_valid, .tx_word,
      .internal_oscillator, .test_active, .irq
   );
   link_remote_model u_far (
      .clk_sys, .arst_n, .lock_req, .test_req, .osc_req, .f_go, .f_bad, .f_pay, .tx_valid,
      .bc_lock, .bc_test_enable, .bc_clock_select, .bc_frm_valid, .bc_frm_payload,
      .bc_frm_crc, .pass_out
   );

   initial
   begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   // Video keeps changing so an ignored input is told apart from a used one
   always @(posedge clk_sys)
   begin
      if (!arst_n)
      begin
         vid_valid <= 1'b0;
         vid_data <= '0;
      end
      else
      begin
         vid_valid <= ~vid_valid;
         vid_data <= vid_data + 24'h000001;
      end
   end

   task automatic end_of_test();
      begin
         if (error_cnt == 0 && checks_done > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask : end_of_test

   task automatic timeout();
      begin
         error_cnt++;
         $display("[ERR] %0t wait bound exceeded", $time);
         end_of_test();
      end
   endtask : timeout

   task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      begin
         checks_done++;
         if (got !== exp)
         begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
         end
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      int n;
      begin
         @(posedge clk_sys);
         psel <= 1'b1;
         pwrite <= wr;
         paddr <= a;
         pwdata <= d;
         @(posedge clk_sys);
         penable <= 1'b1;
         n = 0;
         do
         begin
            @(posedge clk_sys);
            n++;
         end
         while (pready !== 1'b1 && n < 20);
         if (pready !== 1'b1)
            timeout();
         rd = prdata;
         er = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask : apb

   task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      begin
         apb(1'b0, a, '0);
         chk(rd, exp);
      end
   endtask : rdchk

   task automatic frm(input logic bad, input logic [BC_W-1:0] p);
      begin
         @(posedge clk_sys);
         f_go <= 1'b1;
         f_bad <= bad;
         f_pay <= p;
         @(posedge clk_sys);
         f_go <= 1'b0;
         repeat (5) @(posedge clk_sys);
      end
   endtask : frm

   task automatic wait_on(input logic want);
      int n;
      begin
         n = 0;
         while (test_active !== want && n < 40)
         begin
            @(posedge clk_sys);
            n++;
         end
         if (test_active !== want)
            timeout();
      end
   endtask : wait_on

   task automatic run(input int k, input logic osc, input logic [DATA_W-1:0] st);
      begin
         osc_req <= osc;
         test_req <= 1'b1;
         wait_on(1'b1);
         rdchk(OFS_BCNT, 32'h0);
         rdchk(OFS_FCNT, 32'h0);
         rdchk(OFS_STAT, st);
         apb(1'b1, OFS_CFG, 32'h20);
         apb(1'b1, OFS_CFG, 32'h0);
         for (int i = 0; i < 8; i++)
         begin
            @(posedge clk_sys);
            #1;
            cap[k][i] = tx_word;
            chk({31'h0, tx_valid}, 32'h1);
         end
      end
   endtask : run

   initial
   begin
      {arst_n, psel, penable, pwrite, lock_req, test_req, osc_req} = '0;
      {f_go, f_bad, paddr, pwdata, f_pay} = '0;
      error_cnt = 0;
      checks_done = 0;
      repeat (16) @(posedge clk_sys);
      arst_n <= 1'b1;
      rdchk(OFS_CFG, 32'h0);
      rdchk(OFS_STAT, 32'h0);
      rdchk(OFS_ISR, 32'h0);
      rdchk(OFS_IMR, 32'h0);
      rdchk(8'h20, 32'h0);
      chk({31'h0, er}, 32'h1);
      apb(1'b1, OFS_CFG, 32'hff);
      rdchk(OFS_CFG, 32'hff);
      apb(1'b1, OFS_CFG, 32'h0);
      frm(1'b1, 16'h1234);
      rdchk(OFS_FCNT, 32'h0);
      lock_req <= 1'b1;
      frm(1'b1, 16'habcd);
      frm(1'b0, 16'h5a5a);
      rdchk(OFS_STAT, 32'h1);
      rdchk(OFS_FCNT, 32'h1);
      rdchk(OFS_BCNT, 32'h0);
      apb(1'b1, OFS_IMR, 32'h7);
      run(0, 1'b0, 32'h3);
      chk({31'h0, irq}, 32'h1);
      frm(1'b1, 16'h0001);
      frm(1'b1, 16'hfffe);
      frm(1'b0, 16'h8000);
      rdchk(OFS_BCNT, 32'h2);
      rdchk(OFS_FCNT, 32'h2);
      test_req <= 1'b0;
      wait_on(1'b0);
      frm(1'b1, 16'h0f0f);
      chk({31'h0, pass_out}, 32'h1);
      rdchk(OFS_BCNT, 32'h2);
      rdchk(OFS_FCNT, 32'h3);
      rdchk(OFS_ISR, 32'h7);
      apb(1'b1, OFS_ISR, 32'h7);
      #1;
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, OFS_IMR, 32'h0);
      run(1, 1'b1, 32'h7);
      chk({31'h0, internal_oscillator}, 32'h1);
      chk({31'h0, irq}, 32'h0);
      rdchk(OFS_ISR, 32'h1);
      apb(1'b1, OFS_IMR, 32'h1);
      #1;
      chk({31'h0, irq}, 32'h1);
      nz = 1'b0;
      for (int i = 0; i < 8; i++)
      begin
         chk({7'h0, cap[1][i]}, {7'h0, cap[0][i]});
         nz = nz | (|cap[0][i][VID_W-1:0]);
      end
      chk({31'h0, nz}, 32'h1);
      end_of_test();
   end

   initial
   begin
      repeat (20000) @(posedge clk_sys);
      timeout();
   end
endmodule : tb_serial_link_bist
`default_nettype wire
